// file: src/sale_hash.sv
`timescale 1ns/1ps
module sale_hash (
  input  wire logic [sale_pkg::MACW-1:0] mac,
  input  wire logic [sale_pkg::FIDW-1:0] vlan_filter_group_id,
  input  wire logic                      vlan_en,
  input  wire logic [1:0]                hash_sel,
  output logic      [sale_pkg::IDXW-1:0] index
);
  import sale_pkg::*;

  logic [CRCW-1:0] crc;
  logic [CRCW-1:0] fold;
  logic [IDXW-1:0] base;
  logic [IDXW-1:0] fid_ext;

  assign crc     = sale_crc16(mac);
  assign fold    = mac[47:32] ^ mac[31:16] ^ mac[15:0];
  // Default VLAN uses filter id zero
  assign fid_ext = vlan_en ? {{(IDXW-FIDW){1'b0}}, vlan_filter_group_id}
                           : '0;

  always_comb begin
    case (hash_sel)
      HASH_CRC:     base = crc[IDXW-1:0];
      HASH_XOR:     base = fold[IDXW-1:0];
      HASH_DIRECT,
      HASH_DIRECT2: base = mac[IDXW-1:0];
      default:      base = mac[IDXW-1:0];
    endcase
  end

  // Sum wraps modulo bucket count
  assign index = IDXW'(base + fid_ext);
endmodule

// file: src/sale_pkg.sv
package sale_pkg;

  localparam int NBKT            = 1024;
  localparam int IDXW            = 10;
  localparam int WAYS            = 4;
  localparam int WAYW            = 2;
  localparam int FIDW            = 7;
  localparam int MACW            = 48;
  localparam int NPORTS          = 7;
  localparam int PORTW           = 3;
  localparam int STATN           = 16;
  localparam int STATW           = 4;
  localparam int RSVN            = 8;
  localparam int RSVW            = 3;
  localparam int LENW            = 14;
  localparam int FRAME_BUF_BYTES = 262144;
  localparam int FREEW           = 19;
  localparam int MCAST_BIT       = 40;
  localparam int CRCW            = 16;

  localparam logic [CRCW-1:0] CRC_POLY = 16'h1021;
  localparam logic [CRCW-1:0] CRC_INIT = 16'h0000;

  localparam logic [1:0] HASH_DIRECT  = 2'h0;
  localparam logic [1:0] HASH_CRC     = 2'h1;
  localparam logic [1:0] HASH_XOR     = 2'h2;
  localparam logic [1:0] HASH_DIRECT2 = 2'h3;

  localparam logic [1:0] TBL_MAIN = 2'h0;
  localparam logic [1:0] TBL_STAT = 2'h1;
  localparam logic [1:0] TBL_RSV  = 2'h2;

  typedef struct packed {
    logic [1:0]        hash_sel;
    logic              vlan_en;
    logic              rsv_en;
    logic [NPORTS-1:0] tail_tag;
  } sale_cfg_t;

  localparam sale_cfg_t CFG_RESET = '{HASH_CRC, 1'b0, 1'b0, 7'h00};

  typedef struct packed {
    logic [MACW-1:0]  da;
    logic [MACW-1:0]  sa;
    logic [FIDW-1:0]  vlan_filter_group_id;
    logic [PORTW-1:0] src_port;
    logic [LENW-1:0]  len;
  } sale_req_t;

  typedef struct packed {
    logic              known;
    logic              from_static;
    logic              admitted;
    logic [NPORTS-1:0] fwd_mask;
  } sale_resp_t;

  typedef struct packed {
    logic [1:0]        tbl;
    logic [IDXW-1:0]   index;
    logic [WAYW-1:0]   way;
    logic              valid;
    logic [MACW-1:0]   mac;
    logic [FIDW-1:0]   vlan_filter_group_id;
    logic [NPORTS-1:0] fwd_mask;
  } sale_swr_t;

  function automatic logic [CRCW-1:0] sale_crc16(input logic [MACW-1:0] d);
    logic [CRCW-1:0] c;
    logic            fb;
    c = CRC_INIT;
    for (int i = MACW - 1; i >= 0; i--) begin
      fb = c[CRCW-1] ^ d[i];
      c  = {c[CRCW-2:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction

endpackage

// file: src/sale_top.sv
`timescale 1ns/1ps
module sale_top #(
  parameter int BUF_BYTES = sale_pkg::FRAME_BUF_BYTES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        cfg_wr,
  input  wire sale_pkg::sale_cfg_t         cfg_in,
  input  wire logic                        swr_valid,
  input  wire sale_pkg::sale_swr_t         swr,
  input  wire logic                        req_valid,
  input  wire sale_pkg::sale_req_t         req,
  input  wire logic                        rel_valid,
  input  wire logic [sale_pkg::LENW-1:0]   rel_len,
  output logic                             resp_valid,
  output sale_pkg::sale_resp_t             resp,
  output logic [sale_pkg::NPORTS-1:0]      host_port,
  output logic                             host_cfg_err,
  output logic                             learn_fail,
  output logic [sale_pkg::IDXW-1:0]        learn_fail_index,
  output logic [sale_pkg::FREEW-1:0]       buf_free
);
  import sale_pkg::*;

  if (BUF_BYTES < 1 || BUF_BYTES >= (1 << FREEW)) begin : g_chk
    $error("BUF_BYTES does not fit the free-space counter");
  end

  localparam logic [FREEW-1:0] BUF_INIT = FREEW'(BUF_BYTES);

  // Main table storage
  logic [MACW-1:0]   mt_mac    [NBKT][WAYS];
  logic [FIDW-1:0]   mt_fid    [NBKT][WAYS];
  logic [NPORTS-1:0] mt_mask   [NBKT][WAYS];
  logic              mt_valid  [NBKT][WAYS];
  logic              mt_static [NBKT][WAYS];
  logic [WAYW-1:0]   mt_oldest [NBKT];

  // Static and reserved tables
  logic [MACW-1:0]   st_mac   [STATN];
  logic [FIDW-1:0]   st_fid   [STATN];
  logic [NPORTS-1:0] st_mask  [STATN];
  logic              st_valid [STATN];
  logic [MACW-1:0]   rv_mac   [RSVN];
  logic [NPORTS-1:0] rv_mask  [RSVN];
  logic              rv_valid [RSVN];

  sale_cfg_t         cfg;
  logic              s1_valid;
  sale_req_t         s1_req;
  logic [IDXW-1:0]   da_index;
  logic [IDXW-1:0]   sa_index;
  logic [IDXW-1:0]   s1_da_idx;
  logic [IDXW-1:0]   s1_sa_idx;
  logic [FIDW-1:0]   key_fid;

  logic [FIDW-1:0]   s1_fid;
  logic [WAYS-1:0]   da_hit;
  logic [WAYS-1:0]   sa_hit;
  logic              st_hit;
  logic [NPORTS-1:0] st_hit_mask;
  logic              rv_hit;
  logic [NPORTS-1:0] rv_hit_mask;
  logic              mt_hit;
  logic              mt_hit_static;
  logic [NPORTS-1:0] mt_hit_mask;
  logic              sa_found;
  logic [WAYW-1:0]   sa_way;
  logic              learn_ok;
  logic              learn_full;
  logic [WAYW-1:0]   learn_way;
  logic              admit;
  logic [FREEW-1:0]  next_buf_free;
  logic [NPORTS-1:0] src_mask;

  function automatic logic [NPORTS-1:0] port_onehot(
    input logic [PORTW-1:0] p
  );
    port_onehot = '0;
    port_onehot[p] = 1'b1;
  endfunction

  function automatic logic key_match(
    input logic [MACW-1:0] a,
    input logic [FIDW-1:0] fa,
    input logic [MACW-1:0] b,
    input logic [FIDW-1:0] fb
  );
    key_match = (a == b) && (fa == fb);
  endfunction

  // Lookup and learn key filter id is zero when VLAN off; software-written entries keep their own id
  assign key_fid = cfg.vlan_en ? req.vlan_filter_group_id : '0;

  sale_hash u_da_hash (
    .mac      (req.da),
    .vlan_filter_group_id      (req.vlan_filter_group_id),
    .vlan_en  (cfg.vlan_en),
    .hash_sel (cfg.hash_sel),
    .index    (da_index)
  );

  sale_hash u_sa_hash (
    .mac      (req.sa),
    .vlan_filter_group_id      (req.vlan_filter_group_id),
    .vlan_en  (cfg.vlan_en),
    .hash_sel (cfg.hash_sel),
    .index    (sa_index)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg <= cfg_in;
    end
  end

  // Lowest tagged port wins; extra tags are flagged
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      host_port    <= '0;
      host_cfg_err <= 1'b0;
    end else begin
      host_port    <= cfg.tail_tag & (~cfg.tail_tag + 1'b1);
      host_cfg_err <= (cfg.tail_tag & (cfg.tail_tag - 1'b1)) != 0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_valid  <= 1'b0;
      s1_req    <= '0;
      s1_da_idx <= '0;
      s1_sa_idx <= '0;
      s1_fid    <= '0;
    end else begin
      s1_valid  <= req_valid;
      s1_req    <= req;
      s1_da_idx <= da_index;
      s1_sa_idx <= sa_index;
      s1_fid    <= key_fid;
    end
  end

  // Bucket compare, all ways at once
  always_comb begin
    for (int w = 0; w < WAYS; w++) begin
      da_hit[w] = mt_valid[s1_da_idx][w] &&
        key_match(mt_mac[s1_da_idx][w], mt_fid[s1_da_idx][w],
                  s1_req.da, s1_fid);
      sa_hit[w] = mt_valid[s1_sa_idx][w] &&
        key_match(mt_mac[s1_sa_idx][w], mt_fid[s1_sa_idx][w],
                  s1_req.sa, s1_fid);
    end
  end

  always_comb begin
    st_hit      = 1'b0;
    st_hit_mask = '0;
    for (int i = STATN - 1; i >= 0; i--) begin
      if (st_valid[i] && key_match(st_mac[i], st_fid[i],
                                   s1_req.da, s1_fid)) begin
        st_hit      = 1'b1;
        st_hit_mask = st_mask[i];
      end
    end
    rv_hit      = 1'b0;
    rv_hit_mask = '0;
    for (int i = RSVN - 1; i >= 0; i--) begin
      if (cfg.rsv_en && rv_valid[i] && rv_mac[i] == s1_req.da) begin
        rv_hit      = 1'b1;
        rv_hit_mask = rv_mask[i];
      end
    end
  end

  // A static way in the bucket is preferred to a dynamic one
  always_comb begin
    mt_hit        = 1'b0;
    mt_hit_static = 1'b0;
    mt_hit_mask   = '0;
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (da_hit[w] && !mt_static[s1_da_idx][w] && !mt_hit_static) begin
        mt_hit      = 1'b1;
        mt_hit_mask = mt_mask[s1_da_idx][w];
      end
    end
    for (int w = WAYS - 1; w >= 0; w--) begin
      if (da_hit[w] && mt_static[s1_da_idx][w]) begin
        mt_hit        = 1'b1;
        mt_hit_static = 1'b1;
        mt_hit_mask   = mt_mask[s1_da_idx][w];
      end
    end
  end

  // Learning victim: free way, else oldest dynamic from the pointer
  always_comb begin
    logic [WAYW-1:0] w;
    logic            got;
    w          = '0;
    got        = 1'b0;
    sa_found   = |sa_hit;
    sa_way     = '0;
    learn_way  = '0;
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (sa_hit[i]) begin
        sa_way = WAYW'(i);
      end
    end
    for (int i = WAYS - 1; i >= 0; i--) begin
      if (!mt_valid[s1_sa_idx][i]) begin
        learn_way = WAYW'(i);
        got       = 1'b1;
      end
    end
    for (int i = 0; i < WAYS; i++) begin
      w = WAYW'(mt_oldest[s1_sa_idx] + WAYW'(i));
      if (!got && !mt_static[s1_sa_idx][w]) begin
        learn_way = w;
        got       = 1'b1;
      end
    end
    learn_ok   = s1_valid && !s1_req.sa[MCAST_BIT] && !sa_found && got;
    learn_full = s1_valid && !s1_req.sa[MCAST_BIT] && !sa_found && !got;
  end

  assign src_mask = port_onehot(s1_req.src_port);

  // Store-and-forward admission against the shared buffer
  always_comb begin
    logic [FREEW-1:0] after_rel;
    after_rel = buf_free;
    if (rel_valid) begin
      after_rel = FREEW'(buf_free + FREEW'(rel_len));
    end
    if (after_rel > BUF_INIT) begin
      after_rel = BUF_INIT;
    end
    admit         = s1_valid && (buf_free >= FREEW'(s1_req.len));
    next_buf_free = admit ? FREEW'(after_rel - FREEW'(s1_req.len))
                          : after_rel;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      buf_free <= BUF_INIT;
    end else begin
      buf_free <= next_buf_free;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp       <= '0;
    end else begin
      resp_valid <= s1_valid;
      // Fields hold between answers; stage data is stale when idle
      if (s1_valid) begin
        resp.admitted    <= admit;
        resp.known       <= st_hit || rv_hit || mt_hit;
        resp.from_static <= st_hit || rv_hit || mt_hit_static;
        if (st_hit) begin
          resp.fwd_mask <= st_hit_mask;
        end else if (rv_hit) begin
          resp.fwd_mask <= rv_hit_mask;
        end else if (mt_hit) begin
          resp.fwd_mask <= mt_hit_mask;
        end else begin
          resp.fwd_mask <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      learn_fail       <= 1'b0;
      learn_fail_index <= '0;
    end else begin
      learn_fail <= learn_full && !swr_valid;
      if (learn_full && !swr_valid) begin
        learn_fail_index <= s1_sa_idx;
      end
    end
  end

  // Software write owns the table that cycle; learning skips
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int b = 0; b < NBKT; b++) begin
        mt_oldest[b] <= '0;
        for (int w = 0; w < WAYS; w++) begin
          mt_valid[b][w]  <= 1'b0;
          mt_static[b][w] <= 1'b0;
        end
      end
    end else if (swr_valid) begin
      if (swr.tbl == TBL_MAIN) begin
        mt_valid[swr.index][swr.way]  <= swr.valid;
        mt_static[swr.index][swr.way] <= swr.valid;
        mt_mac[swr.index][swr.way]    <= swr.mac;
        mt_fid[swr.index][swr.way]    <= swr.vlan_filter_group_id;
        mt_mask[swr.index][swr.way]   <= swr.fwd_mask;
      end
    end else if (learn_ok) begin
      mt_valid[s1_sa_idx][learn_way]  <= 1'b1;
      mt_static[s1_sa_idx][learn_way] <= 1'b0;
      mt_mac[s1_sa_idx][learn_way]    <= s1_req.sa;
      mt_fid[s1_sa_idx][learn_way]    <= s1_fid;
      mt_mask[s1_sa_idx][learn_way]   <= src_mask;
      mt_oldest[s1_sa_idx]            <= WAYW'(learn_way + 1'b1);
    end else if (s1_valid && sa_found &&
                 !mt_static[s1_sa_idx][sa_way] &&
                 mt_mask[s1_sa_idx][sa_way] != src_mask) begin
      mt_mask[s1_sa_idx][sa_way] <= src_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < STATN; i++) begin
        st_valid[i] <= 1'b0;
      end
      for (int i = 0; i < RSVN; i++) begin
        rv_valid[i] <= 1'b0;
      end
    end else if (swr_valid && swr.tbl == TBL_STAT) begin
      st_valid[swr.index[STATW-1:0]] <= swr.valid;
      st_mac[swr.index[STATW-1:0]]   <= swr.mac;
      st_fid[swr.index[STATW-1:0]]   <= swr.vlan_filter_group_id;
      st_mask[swr.index[STATW-1:0]]  <= swr.fwd_mask;
    end else if (swr_valid && swr.tbl == TBL_RSV) begin
      rv_valid[swr.index[RSVW-1:0]] <= swr.valid;
      rv_mac[swr.index[RSVW-1:0]]   <= swr.mac;
      rv_mask[swr.index[RSVW-1:0]]  <= swr.fwd_mask;
    end
  end

endmodule

// file: tb/sale_rx_model.sv
`timescale 1ns/1ps
module sale_rx_model (
  input  wire logic          clk,
  output logic               req_valid,
  output sale_pkg::sale_req_t req
);
  import sale_pkg::*;
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  // Good frames only; fields scrambled once the pulse is over
  task automatic send(input sale_req_t r);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req       = r;
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req       = ~r;
  endtask
endmodule

// file: tb/sale_top_assertions.sv
`timescale 1ns/1ps
module sale_top_assertions #(
  parameter int BUF_BYTES = 4096
) (
  input wire logic                      clk,
  input wire logic                      rst_n,
  input wire logic                      req_valid,
  input wire sale_pkg::sale_req_t       req,
  input wire logic                      rel_valid,
  input wire logic                      resp_valid,
  input wire sale_pkg::sale_resp_t      resp,
  input wire logic [sale_pkg::NPORTS-1:0] host_port,
  input wire logic                      host_cfg_err,
  input wire logic                      learn_fail,
  input wire logic [sale_pkg::IDXW-1:0] learn_fail_index,
  input wire logic [sale_pkg::FREEW-1:0] buf_free
);
  import sale_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    req_valid;
  endsequence
  sequence s_answer;
    ##2 resp_valid;
  endsequence
  a_answer_lat: assert property (s_taken |-> s_answer)
    else $error("answer not two cycles after request");
  a_no_spurious: assert property (resp_valid |-> $past(req_valid, 2))
    else $error("answer without request");
  a_resp_held: assert property (!resp_valid |-> $stable(resp))
    else $error("answer fields moved between answers");
  a_unknown_mask: assert property (
    resp_valid && !resp.known |-> resp.fwd_mask == '0)
    else $error("unknown destination with ports");
  a_static_known: assert property (resp.from_static |-> resp.known)
    else $error("static flag without hit");
  a_buf_bound: assert property (buf_free <= BUF_BYTES)
    else $error("free bytes above buffer size");
  a_admit_take: assert property (
    resp_valid && resp.admitted && !$past(rel_valid)
    |-> buf_free == $past(buf_free) - $past(req.len, 2))
    else $error("admitted frame not deducted");
  a_refuse_keep: assert property (
    resp_valid && !resp.admitted && !$past(rel_valid)
    |-> $stable(buf_free))
    else $error("refused frame changed free count");
  a_host_one: assert property (
    $onehot0(host_port) && (!host_cfg_err || host_port != '0))
    else $error("host port not single");
  a_fail_timing: assert property (learn_fail |-> resp_valid)
    else $error("learn failure outside answer");
  a_fail_idx: assert property (!learn_fail |-> $stable(learn_fail_index))
    else $error("failure index moved without failure");
endmodule

bind sale_top sale_top_assertions #(.BUF_BYTES(BUF_BYTES)) sale_chk_i (
  .clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .rel_valid(rel_valid), .resp_valid(resp_valid), .resp(resp),
  .host_port(host_port), .host_cfg_err(host_cfg_err),
  .learn_fail(learn_fail), .learn_fail_index(learn_fail_index),
  .buf_free(buf_free)
);

// file: tb/sale_top_tb_top.sv
`timescale 1ns/1ps
module sale_top_tb_top;
  import sale_pkg::*;
  typedef struct packed {
    logic [1:0]  s;
    logic        v;
    logic [47:0] m;
    logic [6:0]  f;
    logic [6:0]  p;
  } sale_row_t;
  localparam int BUFB = 4096;
  localparam logic [47:0] MC = 48'h010000000000;
  logic clk, rst_n, cfg_wr, swr_valid, req_valid, rel_valid, resp_valid;
  logic host_cfg_err, learn_fail;
  logic [13:0] rel_len;
  logic [6:0]  host_port;
  logic [9:0]  learn_fail_index;
  logic [18:0] buf_free;
  sale_cfg_t   cfg_in;
  sale_swr_t   swr;
  sale_req_t   req;
  sale_resp_t  resp;
  int fail_count, cmp_count, cyc;
  sale_row_t rows[5] = '{
    '{2'h1, 1'b0, 48'h0A1B2C3D4E5F, 7'h05, 7'h01},
    '{2'h1, 1'b1, 48'h00112233AA55, 7'h7F, 7'h02},
    '{2'h2, 1'b1, 48'h123456789ABC, 7'h11, 7'h04},
    '{2'h0, 1'b1, 48'h0000000003FF, 7'h7F, 7'h08},
    '{2'h3, 1'b0, 48'h0000CAFE0123, 7'h22, 7'h10}};

  sale_top #(.BUF_BYTES(BUFB)) sale_top_i (
    .clk(clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .swr_valid(swr_valid), .swr(swr), .req_valid(req_valid), .req(req),
    .rel_valid(rel_valid), .rel_len(rel_len), .resp_valid(resp_valid),
    .resp(resp), .host_port(host_port), .host_cfg_err(host_cfg_err),
    .learn_fail(learn_fail), .learn_fail_index(learn_fail_index),
    .buf_free(buf_free));
  sale_rx_model sale_rx_model_i (.clk(clk), .req_valid(req_valid),
    .req(req));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Own model of the bucket hash, kept apart from the design's function
  function automatic logic [9:0] idx(logic [1:0] s, logic v,
                                     logic [47:0] m, logic [6:0] f);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 47; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h1021 : 16'h0000);
    end
    if (s == 2'h2) c = m[47:32] ^ m[31:16] ^ m[15:0];
    if (s[0] == s[1]) c = m[15:0];
    return c[9:0] + (v ? {3'h0, f} : 10'h000);
  endfunction

  task automatic cfg(input logic [1:0] s, input logic v,
                     input logic [6:0] tt);
    @(posedge clk);
    #1;
    cfg_wr = 1'b1;
    cfg_in = '{s, v, 1'b0, tt};
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
  endtask

  task automatic wr(input logic [1:0] t, input logic [9:0] ix,
                    input logic [1:0] w, input logic [47:0] m,
                    input logic [6:0] f, input logic [6:0] p);
    @(posedge clk);
    #1;
    swr_valid = 1'b1;
    swr       = '{t, ix, w, 1'b1, m, f, p};
    @(posedge clk);
    #1;
    swr_valid = 1'b0;
  endtask

  task automatic look(input logic [47:0] da, sa, input logic [6:0] f,
                      input logic [2:0] sp, input logic [13:0] len);
    sale_rx_model_i.send('{da, sa, f, sp, len});
    @(posedge clk);
    #2;
  endtask

  task automatic rel(input logic [13:0] n);
    @(posedge clk);
    #1;
    rel_valid = 1'b1;
    rel_len   = n;
    @(posedge clk);
    #1;
    rel_valid = 1'b0;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    {rst_n, cfg_wr, swr_valid, rel_valid, rel_len} = '0;
    cfg_in = CFG_RESET;
    swr    = '0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    foreach (rows[k]) begin
      cfg(rows[k].s, rows[k].v, 7'h00);
      wr(2'h0, idx(rows[k].s, rows[k].v, rows[k].m, rows[k].f), 2'h0,
         rows[k].m, rows[k].v ? rows[k].f : 7'h00, rows[k].p);
      look(rows[k].m, MC, rows[k].f, 3'h0, 14'd64);
      chk(resp_valid, 1);
      chk(resp, {3'b111, rows[k].p});
      $display("row %0d done", k);
    end
    cfg(2'h0, 1'b0, 7'h00);
    for (int w = 0; w < 4; w++) begin
      wr(2'h0, 10'h155, w[1:0], 48'h0000000A0155 + 48'(w), 7'h00, 7'h01);
    end
    look(48'h0000000000AA, 48'h000000000155, 7'h00, 3'h1, 14'd64);
    chk(learn_fail, 1);
    chk(learn_fail_index, 10'h155);
    $display("full static bucket done");
    look(48'h0000000000AA, 48'h000000000234, 7'h00, 3'h2, 14'd64);
    look(48'h000000000234, MC, 7'h00, 3'h0, 14'd64);
    chk(resp, {3'b101, 7'h04});
    wr(2'h1, 10'h003, 2'h0, 48'h000000000234, 7'h00, 7'h20);
    look(48'h000000000234, MC, 7'h00, 3'h0, 14'd64);
    chk(resp, {3'b111, 7'h20});
    $display("priority done");
    cfg(2'h1, 1'b0, 7'h50);
    @(posedge clk);
    #2;
    chk({host_cfg_err, host_port}, {1'b1, 7'h10});
    $display("host port done");
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk({resp_valid, host_port, buf_free}, {8'h00, 19'(BUFB)});
    look(48'h0000000000AA, MC, 7'h00, 3'h0, 14'd3000);
    chk(resp, {3'b001, 7'h00});
    chk(buf_free, BUFB - 3000);
    look(48'h0000000000AA, MC, 7'h00, 3'h0, 14'd2000);
    chk(resp, 0);
    chk(buf_free, BUFB - 3000);
    rel(14'd3000);
    chk(buf_free, BUFB);
    rel(14'd100);
    chk(buf_free, BUFB);
    $display("buffer done");
    wrap_up();
  end
endmodule
